//--- rtl/isr_pkg.sv
/*
 * Shared types and constants of the idle state resolver.
 * Assumes one 40 MHz clock for cores, platform agent and register bus.
 */
package isr_pkg;

    // Core idle levels, ordered so that a larger code is a deeper state.
    typedef enum logic [3:0] {
        CORE_ACTIVE     = 4'h0,
        CORE_HALT       = 4'h1,
        CORE_HALT_LV    = 4'h2,
        CORE_OFF        = 4'h3,
        CORE_OFF_MODULE = 4'h4,
        CORE_SHRINK_7   = 4'h5,
        CORE_SHRINK_8   = 4'h6,
        CORE_SHRINK_9   = 4'h7,
        CORE_DEEPEST    = 4'h8
    } isr_core_t;

    // Package states; the code is the package depth, transit is extra.
    typedef enum logic [3:0] {
        PKG_ACTIVE  = 4'h0,
        PKG_TRANSIT = 4'h1,
        PKG_INTER   = 4'h2,
        PKG_SELF_RF = 4'h3,
        PKG_6       = 4'h6,
        PKG_7       = 4'h7,
        PKG_8       = 4'h8,
        PKG_9       = 4'h9,
        PKG_10      = 4'ha
    } isr_pstate_t;

    localparam int ISR_AW     = 8;
    localparam int ISR_IO_W   = 16;
    localparam int ISR_IDX_W  = 3;
    localparam int ISR_MAXC   = 8;

    // Register byte offsets.
    localparam logic [ISR_AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [ISR_AW-1:0] REG_IOCAP  = 8'h04;
    localparam logic [ISR_AW-1:0] REG_THR    = 8'h08;
    localparam logic [ISR_AW-1:0] REG_STATUS = 8'h0c;
    localparam logic [ISR_AW-1:0] REG_CORES  = 8'h10;

    // Field positions.
    localparam int CTRL_REDIR  = 0;
    localparam int CTRL_DEMOTE = 1;
    localparam int CTRL_LOWV   = 2;
    localparam int IOCAP_RANGE = 16;
    localparam int ST_MODOFF   = 4;
    localparam int ST_MEMSR    = 5;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic        valid;
        isr_core_t   level;
        logic [3:0]  hint;
        logic        brk_irq;
        logic        monitor;
    } isr_core_req_t;

    typedef struct packed {
        logic                 valid;
        logic [ISR_IO_W-1:0]  addr;
        logic [ISR_IDX_W-1:0] core;
    } isr_io_rd_t;

    typedef struct packed {
        logic                 valid;
        logic [ISR_IDX_W-1:0] target;
    } isr_irq_t;

    typedef struct packed {
        logic        permit;
        logic [3:0]  ltr_depth;
        logic        gfx_off;
        logic        mem_busy;
        logic        keep_high;
        logic        timer_near;
    } isr_plat_t;

    typedef struct packed {
        logic              awvalid;
        logic [ISR_AW-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ISR_AW-1:0] araddr;
        logic              rready;
    } isr_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } isr_axi_rsp_t;

endpackage

//--- rtl/isr_resolver.sv
/*
 * Idle state resolver: core, module and package idle state control,
 * legacy read redirection, core auto-demotion and an AXI4-Lite slave.
 * Assumes cores and the platform agent run on clk_i, so no inputs
 * need synchronising, and that the platform holds its levels stable.
 */
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps

// Notes on behaviour
// [RULE1] Idle core wakes on interrupt, monitored-address hit, or timed-wait deadline.
// [RULE2] A core only takes an idle request while active.
// [RULE3] An interrupt may target and wake any core.
// [RULE4] Reset returns every core to active, dropping held idle states.
// [RULE5] With redirection on, legacy reads become monitor-wait requests, no I/O cycle.
// [RULE6] Only reads within the programmed range redirect; others pass through.
// [RULE7] Redirected requests carry a zero sub-state hint.
// [RULE8] Redirected requests break on interrupt even when interrupts are masked.
// [RULE9] Halt gates the core clock; halt low voltage also drops voltage point.
// [RULE10] Power off stops clocks, removes voltage; module variant permits module off.
// [RULE11] Shrink states reduce last-level cache; deepest flushes it, enables standby. The code flushes from PKG_8 up.
// [RULE12] Auto-demotion turns power-off requests into halt until residency suffices.
// [RULE13] Auto-demotion is off after reset.
// [RULE14] Module active with any core active; off only when all cores off.
// [RULE15] Package request is the shallowest core state plus module state.
// [RULE16] Without platform permission the package stays shallower than cores.
// [RULE17] Package moves between idle states without visiting active.
// [RULE18] Core break wakes target; unmasked wakes package, masked keeps it.
// [RULE19] Memory break returns package to previous state unless platform holds higher.
// [RULE20] Entry and exit of package states three and deeper pass transit.
// [RULE21] Intermediate package state is entered by hardware, never by software.
// [RULE22] Self refresh needs cores off, graphics off and latency tolerance.
// [RULE23] Platform permission and latency tolerance are stable before each decision.
module isr_resolver
    import isr_pkg::*;
#(
    parameter int N_CORES = 4,
    parameter int RES_W   = 16
) (
    input  wire logic                          clk_i,
    input  wire logic                          reset_n_i,
    input  isr_pkg::isr_core_req_t [N_CORES-1:0] core_req_i,
    input  wire logic [N_CORES-1:0]            ie_flag_i,
    input  wire logic [N_CORES-1:0]            monitor_hit_i,
    input  wire logic [N_CORES-1:0]            deadline_i,
    input  isr_pkg::isr_irq_t                  irq_i,
    input  isr_pkg::isr_io_rd_t                io_rd_i,
    input  isr_pkg::isr_plat_t                 plat_i,
    input  isr_pkg::isr_axi_req_t              axi_i,
    output isr_pkg::isr_axi_rsp_t              axi_o,
    output isr_pkg::isr_core_t [N_CORES-1:0]   core_state_o,
    output logic [N_CORES-1:0]                 core_wake_o,
    output logic [N_CORES-1:0]                 core_clk_gate_o,
    output logic [N_CORES-1:0]                 core_low_v_o,
    output logic [N_CORES-1:0]                 core_pwr_off_o,
    output logic                               module_off_o,
    output isr_pkg::isr_pstate_t               pkg_state_o,
    output logic                               mem_self_refresh_o,
    output logic                               llc_shrink_o,
    output logic                               llc_flush_o,
    output logic                               standby_en_o,
    output logic                               io_pass_o,
    output logic [isr_pkg::ISR_IO_W-1:0]       io_pass_addr_o
);
    import isr_pkg::*;

    // Refuse sizes that the index, threshold and cores registers cannot carry.
    if (N_CORES < 1 || N_CORES > ISR_MAXC || RES_W < 1 || RES_W > 32) begin : g_bad
        $error("N_CORES must be 1 to 8, RES_W 1 to 32");
    end

    typedef struct packed {
        isr_core_t [N_CORES-1:0]            core;
        logic [N_CORES-1:0][3:0]            hint;
        logic [N_CORES-1:0]                 brk;
        logic [N_CORES-1:0]                 mon;
        logic [N_CORES-1:0]                 earned;
        logic [N_CORES-1:0][RES_W-1:0]      res;
        logic [N_CORES-1:0]                 wake;
        logic [N_CORES-1:0]                 gate;
        logic [N_CORES-1:0]                 lowv;
        logic [N_CORES-1:0]                 poff;
        isr_pstate_t                        pkg;
        logic                               mod_off;
        logic                               mem_sr;
        logic                               shrink;
        logic                               flush;
        logic                               standby;
        logic                               io_pass;
        logic [ISR_IO_W-1:0]                io_addr;
        logic                               redir;
        logic                               demote_en;
        logic                               demote_lv;
        logic [ISR_IO_W-1:0]                io_base;
        logic [7:0]                         io_range;
        logic [RES_W-1:0]                   thr;
        logic                               aw_got;
        logic                               w_got;
        logic [ISR_AW-1:0]                  awaddr;
        logic [31:0]                        wdata;
        logic [3:0]                         wstrb;
        isr_axi_rsp_t                       rsp;
    } isr_state_t;

    isr_state_t st_reg;
    isr_state_t st_next;

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] isr_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Package depth that a given shallowest core level asks for.
    function automatic isr_pstate_t isr_map(input isr_core_t lvl);
        isr_pstate_t p;
        unique case (lvl)
            CORE_SHRINK_7: p = PKG_7;
            CORE_SHRINK_8: p = PKG_8;
            CORE_SHRINK_9: p = PKG_9;
            CORE_DEEPEST:  p = PKG_10;
            default:       p = PKG_6;
        endcase
        return p;
    endfunction

    // Next-state logic for cores, module, package and the register bus.
    always_comb begin
        isr_core_t     min_lvl;
        isr_core_t     lvl;
        isr_pstate_t   cand;
        isr_pstate_t   tgt;
        logic          all_mod;
        logic          any_req;
        logic          in_rng;
        logic          wake_c;
        logic          irq_hit;
        logic [ISR_IO_W-1:0] off;
        logic [31:0]   cur;
        logic [31:0]   rd;
        logic [1:0]    rr;
        min_lvl = CORE_DEEPEST;
        lvl     = CORE_ACTIVE;
        cand    = PKG_ACTIVE;
        tgt     = PKG_ACTIVE;
        all_mod = 1'b1;
        any_req = 1'b0;
        wake_c  = 1'b0;
        irq_hit = 1'b0;
        cur     = 32'h0000_0000;
        rd      = 32'h0000_0000;
        rr      = RESP_OKAY;
        st_next = st_reg;
        st_next.wake    = '0;
        st_next.io_pass = 1'b0;

        // Legacy read decode; reads outside the window fall through.
        off    = io_rd_i.addr - st_reg.io_base;
        in_rng = st_reg.redir && io_rd_i.addr >= st_reg.io_base
                 && off < ISR_IO_W'(st_reg.io_range);                  // [RULE6]
        if (io_rd_i.valid && !in_rng) begin
            st_next.io_pass = 1'b1; // [RULE6]
            st_next.io_addr = io_rd_i.addr;
        end

        for (int i = 0; i < N_CORES; i++) begin
            irq_hit = irq_i.valid && irq_i.target == ISR_IDX_W'(i);      // [RULE3]
            if (st_reg.core[i] != CORE_ACTIVE) begin
                wake_c = (irq_hit && (ie_flag_i[i] || st_reg.brk[i]))
                         || (st_reg.mon[i] && monitor_hit_i[i])
                         || deadline_i[i]; // [RULE1]
                st_next.wake[i] = irq_hit; // [RULE18]
                if (wake_c) begin
                    st_next.core[i]   = CORE_ACTIVE; // [RULE1]
                    st_next.earned[i] = st_reg.res[i] >= st_reg.thr;     // [RULE12]
                    st_next.res[i]    = '0;
                end else if (st_reg.res[i] != '1) begin
                    st_next.res[i] = st_reg.res[i] + 1'b1;
                end
            end else begin
                // Only an active core takes a new request.
                any_req = 1'b0; // [RULE2]
                if (io_rd_i.valid && in_rng && io_rd_i.core == ISR_IDX_W'(i)) begin
                    any_req = 1'b1; // [RULE5]
                    lvl = (off >= ISR_IO_W'(CORE_DEEPEST)) ? CORE_DEEPEST
                          : isr_core_t'(off[3:0] + 4'h1);
                    st_next.hint[i] = 4'h0; // [RULE7]
                    st_next.brk[i]  = 1'b1; // [RULE8]
                    st_next.mon[i]  = 1'b1;
                end else if (core_req_i[i].valid && core_req_i[i].level != CORE_ACTIVE) begin
                    any_req = 1'b1;
                    lvl = core_req_i[i].level;
                    st_next.hint[i] = core_req_i[i].hint;
                    st_next.brk[i]  = core_req_i[i].brk_irq;
                    st_next.mon[i]  = core_req_i[i].monitor;
                end
                if (any_req) begin
                    if (st_reg.demote_en && lvl >= CORE_OFF && !st_reg.earned[i]) begin
                        lvl = st_reg.demote_lv ? CORE_HALT_LV : CORE_HALT; // [RULE12]
                    end
                    st_next.core[i] = lvl;
                end
            end
            st_next.gate[i] = st_next.core[i] != CORE_ACTIVE; // [RULE9]
            st_next.lowv[i] = st_next.core[i] == CORE_HALT_LV; // [RULE9]
            st_next.poff[i] = st_next.core[i] >= CORE_OFF; // [RULE10]
            if (st_next.core[i] < min_lvl) begin
                min_lvl = st_next.core[i]; // [RULE15]
            end
            if (st_next.core[i] < CORE_OFF_MODULE) begin
                all_mod = 1'b0; // [RULE10]
            end
        end
        st_next.mod_off = all_mod; // [RULE14]

        // Package target from shallowest core, module, and platform limits.
        if (min_lvl < CORE_OFF) begin
            cand = PKG_ACTIVE; // [RULE15]
        end else if (!all_mod || !plat_i.permit || !plat_i.gfx_off) begin
            cand = PKG_INTER; // [RULE16]
        end else if (plat_i.mem_busy || plat_i.keep_high || plat_i.timer_near) begin
            cand = PKG_INTER; // [RULE19]
        end else begin
            cand = isr_map(min_lvl); // [RULE15]
            if (plat_i.ltr_depth < 4'(cand)) begin
                if (plat_i.ltr_depth >= 4'(PKG_6)) begin
                    cand = isr_pstate_t'(plat_i.ltr_depth); // [RULE23]
                end else if (plat_i.ltr_depth >= 4'(PKG_SELF_RF)) begin
                    cand = PKG_SELF_RF; // [RULE22]
                end else begin
                    cand = PKG_INTER; // [RULE21]
                end
            end
        end
        tgt = cand;

        // Package state walk: hardware alone chooses the intermediate state.
        unique case (st_reg.pkg)
            PKG_ACTIVE: begin
                if (tgt != PKG_ACTIVE) begin
                    st_next.pkg = PKG_INTER; // [RULE21]
                end
            end
            PKG_INTER: begin
                if (tgt == PKG_ACTIVE) begin
                    st_next.pkg = PKG_ACTIVE; // [RULE18]
                end else if (tgt != PKG_INTER) begin
                    st_next.pkg = PKG_TRANSIT; // [RULE20]
                end
            end
            PKG_TRANSIT: begin
                st_next.pkg = (tgt <= PKG_INTER) ? PKG_INTER : tgt; // [RULE17]
            end
            PKG_SELF_RF, PKG_6, PKG_7, PKG_8, PKG_9, PKG_10: begin
                if (tgt != st_reg.pkg) begin
                    st_next.pkg = PKG_TRANSIT; // [RULE20]
                end
            end
            default: begin
                st_next.pkg = PKG_ACTIVE;
            end
        endcase
        st_next.mem_sr  = st_next.pkg >= PKG_SELF_RF; // [RULE22]
        st_next.shrink  = st_next.pkg >= PKG_7; // [RULE11]
        st_next.flush   = st_next.pkg >= PKG_8; // [RULE11]
        st_next.standby = st_next.pkg == PKG_10; // [RULE11]

        // Register bus write path: address and data may come in any order.
        if (axi_i.awvalid && st_reg.rsp.awready) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = axi_i.awaddr;
        end
        if (axi_i.wvalid && st_reg.rsp.wready) begin
            st_next.w_got = 1'b1;
            st_next.wdata = axi_i.wdata;
            st_next.wstrb = axi_i.wstrb;
        end
        if (st_reg.aw_got && st_reg.w_got && !st_reg.rsp.bvalid) begin
            st_next.aw_got     = 1'b0;
            st_next.w_got      = 1'b0;
            st_next.rsp.bvalid = 1'b1;
            st_next.rsp.bresp  = RESP_OKAY;
            unique case ({st_reg.awaddr[ISR_AW-1:2], 2'b00})
                REG_CTRL: begin
                    cur = isr_merge({29'h0, st_reg.demote_lv, st_reg.demote_en,
                                     st_reg.redir}, st_reg.wdata, st_reg.wstrb);
                    st_next.redir     = cur[CTRL_REDIR];
                    st_next.demote_en = cur[CTRL_DEMOTE];
                    st_next.demote_lv = cur[CTRL_LOWV];
                end
                REG_IOCAP: begin
                    cur = isr_merge({8'h00, st_reg.io_range, st_reg.io_base},
                                    st_reg.wdata, st_reg.wstrb);
                    st_next.io_base  = cur[ISR_IO_W-1:0];
                    st_next.io_range = cur[IOCAP_RANGE +: 8];
                end
                REG_THR: begin
                    cur = isr_merge(32'(st_reg.thr), st_reg.wdata, st_reg.wstrb);
                    st_next.thr = cur[RES_W-1:0];
                end
                REG_STATUS, REG_CORES: begin
                    st_next.rsp.bresp = RESP_OKAY;
                end
                default: begin
                    st_next.rsp.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (st_reg.rsp.bvalid && axi_i.bready) begin
            st_next.rsp.bvalid = 1'b0;
        end

        // Register bus read path: data is captured at the address handshake.
        unique case ({axi_i.araddr[ISR_AW-1:2], 2'b00})
            REG_CTRL:   rd = {29'h0, st_reg.demote_lv, st_reg.demote_en, st_reg.redir};
            REG_IOCAP:  rd = {8'h00, st_reg.io_range, st_reg.io_base};
            REG_THR:    rd = 32'(st_reg.thr);
            REG_STATUS: rd = {26'h0, st_reg.mem_sr, st_reg.mod_off, 4'(st_reg.pkg)};
            REG_CORES:  rd = 32'(st_reg.core);
            default:    rr = RESP_SLVERR;
        endcase
        if (axi_i.arvalid && st_reg.rsp.arready) begin
            st_next.rsp.rvalid = 1'b1;
            st_next.rsp.rdata  = rd;
            st_next.rsp.rresp  = rr;
        end
        if (st_reg.rsp.rvalid && axi_i.rready) begin
            st_next.rsp.rvalid = 1'b0;
        end
        st_next.rsp.awready = !st_next.aw_got && !st_next.rsp.bvalid;
        st_next.rsp.wready  = !st_next.w_got && !st_next.rsp.bvalid;
        st_next.rsp.arready = !st_next.rsp.rvalid;
    end

    // State register; reset clears every core to active and demotion off.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= '0;                                                // [RULE4] [RULE13]
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register.
    assign axi_o              = st_reg.rsp;
    assign core_state_o       = st_reg.core;
    assign core_wake_o        = st_reg.wake;
    assign core_clk_gate_o    = st_reg.gate;
    assign core_low_v_o       = st_reg.lowv;
    assign core_pwr_off_o     = st_reg.poff;
    assign module_off_o       = st_reg.mod_off;
    assign pkg_state_o        = st_reg.pkg;
    assign mem_self_refresh_o = st_reg.mem_sr;
    assign llc_shrink_o       = st_reg.shrink;
    assign llc_flush_o        = st_reg.flush;
    assign standby_en_o       = st_reg.standby;
    assign io_pass_o          = st_reg.io_pass;
    assign io_pass_addr_o     = st_reg.io_addr;

endmodule

//--- tb/isr_monitor.sv
/* Port checker for isr_resolver; core 0 and the package are watched.
   Assumes it is bound into every isr_resolver instance. */
`timescale 1ns/1ps
module isr_monitor
    import isr_pkg::*;
#(parameter int N_CORES = 4) (
    input wire logic               clk_i,
    input wire logic               reset_n_i,
    input isr_pkg::isr_irq_t       irq_i,
    input wire logic [N_CORES-1:0] ie_flag_i,
    input isr_pkg::isr_core_t [N_CORES-1:0] core_state_o,
    input wire logic [N_CORES-1:0] core_wake_o,
    input wire logic [N_CORES-1:0] core_clk_gate_o,
    input wire logic [N_CORES-1:0] core_pwr_off_o,
    input isr_pkg::isr_pstate_t    pkg_state_o,
    input wire logic               standby_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Core 0 idle flag, interrupt aimed at it, and package moves into or out of deep states.
    wire logic idle0 = core_state_o[0] != CORE_ACTIVE;
    wire logic irq0  = irq_i.valid && irq_i.target == 3'h0;
    sequence s_enter; $changed(pkg_state_o) && pkg_state_o >= PKG_SELF_RF; endsequence
    sequence s_leave; $changed(pkg_state_o) && $past(pkg_state_o) >= PKG_SELF_RF; endsequence
    a_irq_wake: assert property (irq0 && ie_flag_i[0] && idle0 |=> !idle0) else $error("irq wake missed");
    a_wake_fwd: assert property (irq0 && idle0 |=> core_wake_o[0]) else $error("wake not forwarded");
    a_no_hop: assert property (idle0 |=> !idle0 || $stable(core_state_o[0])) else $error("idle hop");
    a_halt_gate: assert property (core_state_o[0] == CORE_HALT |-> core_clk_gate_o[0] && !core_pwr_off_o[0])
        else $error("halt outputs");
    a_off_power: assert property (core_state_o[0] >= CORE_OFF |-> core_pwr_off_o[0] && core_clk_gate_o[0])
        else $error("off outputs");
    a_transit_in: assert property (s_enter |-> $past(pkg_state_o) == PKG_TRANSIT) else $error("entry");
    a_transit_out: assert property (s_leave |-> pkg_state_o == PKG_TRANSIT) else $error("exit");
    a_pkg_active: assert property ((core_state_o[0] < CORE_OFF) [*5] |-> pkg_state_o == PKG_ACTIVE)
        else $error("package not active");
    a_standby_pkg: assert property (standby_en_o |-> pkg_state_o == PKG_10) else $error("standby");
endmodule
bind isr_resolver isr_monitor #(.N_CORES(N_CORES)) mon_u (.*);

//--- tb/isr_plat_model.sv
/* Platform agent model: permission, latency tolerance and memory levels.
   Assumes the bench changes grant and mode right after clock edges. */
`timescale 1ns/1ps
module isr_plat_model
    import isr_pkg::*;
(
    input wire logic         clk_i,
    input wire logic         reset_n_i,
    input wire logic         grant_i,
    input wire logic [1:0]   mode_i,
    output isr_pkg::isr_plat_t plat_o
);
    // Levels are registered, so each stands a full clock before a decision.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            plat_o <= '0;
        end else begin
            plat_o <= '{grant_i, grant_i ? 4'ha : 4'h2, grant_i,
                        mode_i == 2'h1, mode_i == 2'h2, mode_i == 2'h3};
        end
    end
endmodule

//--- tb/isr_resolver_test.sv
/* Bench for isr_resolver: AXI4-Lite and core pulse tasks, package walks.
   Assumes the platform model and the bound checker. */
`timescale 1ns/1ps
module isr_resolver_test;
    import isr_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic grant_q = 1'b0;
    logic [1:0] mode_q = 2'h0;
    logic [3:0] ie_q = 4'h0, dl_q = 4'h0, hit_q = 4'h0, wk, gt, po, lv;
    isr_core_req_t [3:0] req_q = '0;
    isr_irq_t irq_q = '0;
    isr_io_rd_t io_q = '0;
    isr_plat_t plat_w;
    isr_axi_req_t m = '0;
    isr_axi_rsp_t s;
    isr_core_t [3:0] cs;
    isr_pstate_t pk;
    logic sb, ip, mo, sr, sh, fl;
    logic [15:0] ia;
    logic [33:0] rd_d;
    int error_cnt = 0, n_compared = 0;
    // Free-running 40 MHz clock.
    initial forever #12.5 clk_i = ~clk_i;
    isr_plat_model plat_u (.clk_i, .reset_n_i, .grant_i(grant_q), .mode_i(mode_q), .plat_o(plat_w));
    isr_resolver #(.N_CORES(4), .RES_W(16)) dut_u (.clk_i, .reset_n_i, .core_req_i(req_q), .ie_flag_i(ie_q),
        .monitor_hit_i(hit_q), .deadline_i(dl_q), .irq_i(irq_q), .io_rd_i(io_q), .plat_i(plat_w), .axi_i(m),
        .axi_o(s), .core_state_o(cs), .core_wake_o(wk), .core_clk_gate_o(gt), .core_low_v_o(lv),
        .core_pwr_off_o(po), .module_off_o(mo), .pkg_state_o(pk), .mem_self_refresh_o(sr), .llc_shrink_o(sh),
        .llc_flush_o(fl), .standby_en_o(sb), .io_pass_o(ip), .io_pass_addr_o(ia));
    task chk(string n, logic [31:0] g, logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    // One-cycle pulses on the core side, then one edge for the result to land.
    task step(logic [3:0] k, isr_core_t l, logic [3:0] d = 4'h0, logic [3:0] h = 4'h0, isr_irq_t q = '0,
              isr_io_rd_t o = '0);
        @(posedge clk_i);
        for (int i = 0; i < 4; i++) begin
            req_q[i] <= '{k[i], l, 4'h0, 1'b0, 1'b0};
        end
        {dl_q, hit_q, irq_q, io_q} <= {d, h, q, o};
        @(posedge clk_i);
        {req_q, dl_q, hit_q, irq_q, io_q} <= '0;
        @(posedge clk_i);
    endtask
    // One AXI4-Lite write (w high) or read; each valid drops when its channel is taken.
    task bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk_i);
        m <= {w, a, w, d, 4'hf, w, !w, a, !w};
        do begin
            @(posedge clk_i);
            if (w && s.awready) m.awvalid <= 1'b0;
            if (w && s.wready) m.wvalid <= 1'b0;
            if (!w && s.arready) m.arvalid <= 1'b0;
        end while (w ? !s.bvalid : !s.rvalid);
        m <= '0;
        rd_d = {w ? s.bresp : s.rresp, s.rdata};
    endtask
    task automatic wait_pkg(isr_pstate_t v);
        int n = 0;
        while (pk !== v && n < 30) begin
            @(posedge clk_i);
            n++;
        end
        chk("pkg", pk, v);
    endtask
    task give_verdict();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Cuts a hung run short.
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        give_verdict();
    end
    // Reset, then the scenarios in order.
    initial begin
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        bus(1'b0, REG_CTRL, 32'h0000_0000);
        chk("ctrl", rd_d[31:0], 32'h0000_0000);
        bus(1'b0, 8'h40, 32'h0000_0000);
        chk("resp", rd_d[33:32], RESP_SLVERR);
        step(4'h1, CORE_OFF);
        chk("off", {cs[0], po[0]}, {CORE_OFF, 1'b1});
        step(4'h1, CORE_HALT);
        chk("hop", cs[0], CORE_OFF);
        step(4'h0, CORE_ACTIVE, .d(4'h1));
        chk("deadline", cs[0], CORE_ACTIVE);
        step(4'h2, CORE_HALT);
        step(4'h0, CORE_ACTIVE, .q('{1'b1, 3'h1}));
        chk("masked", {wk[1], cs[1], gt[1]}, {1'b1, CORE_HALT, 1'b1});
        ie_q <= 4'hf;
        step(4'h0, CORE_ACTIVE, .q('{1'b1, 3'h1}));
        chk("irq", cs[1], CORE_ACTIVE);
        grant_q <= 1'b1;
        step(4'hf, CORE_DEEPEST);
        wait_pkg(PKG_10);
        chk("deep_out", {mo, sr, sh, fl, sb}, 5'h1f);
        for (int k = 1; k < 4; k++) begin
            mode_q <= 2'(k);
            wait_pkg(PKG_INTER);
            mode_q <= 2'h0;
            wait_pkg(PKG_10);
        end
        grant_q <= 1'b0;
        wait_pkg(PKG_INTER);
        chk("deep", cs[2], CORE_DEEPEST);
        grant_q <= 1'b1;
        step(4'h0, CORE_ACTIVE, .q('{1'b1, 3'h0}));
        wait_pkg(PKG_ACTIVE);
        step(4'h0, CORE_ACTIVE, .d(4'hf));
        bus(1'b1, REG_CTRL, 32'h0000_0001);
        bus(1'b1, REG_IOCAP, 32'h0004_0400);
        bus(1'b1, REG_THR, 32'h0000_00ff);
        step(4'h0, CORE_ACTIVE, .o('{1'b1, 16'h0402, 3'h0}));
        chk("redirect", {ip, cs[0]}, {1'b0, CORE_OFF});
        step(4'h0, CORE_ACTIVE, .h(4'h1));
        chk("monitor", cs[0], CORE_ACTIVE);
        ie_q <= 4'h0;
        step(4'h0, CORE_ACTIVE, .o('{1'b1, 16'h0400, 3'h0}));
        step(4'h0, CORE_ACTIVE, .q('{1'b1, 3'h0}));
        chk("brk", cs[0], CORE_ACTIVE);
        step(4'h0, CORE_ACTIVE, .o('{1'b1, 16'h0500, 3'h0}));
        chk("pass", {ip, ia}, {1'b1, 16'h0500});
        bus(1'b1, REG_CTRL, 32'h0000_0006);
        step(4'h1, CORE_OFF);
        chk("demote", {cs[0], lv[0]}, {CORE_HALT_LV, 1'b1});
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("reset", cs[0], CORE_ACTIVE);
        give_verdict();
    end
endmodule
